// ===== frame_queue_pkg.sv
// Shared constants for the frame queue command registers and their host.
// Assumes one clock (pclk) and one asynchronous low reset on both ends.
`default_nettype none
package frame_queue_pkg;
  // ----------------------------------------
  // Device register byte offsets
  // ----------------------------------------
  localparam logic [7:0] rx_frame_header_byte_count_off = 8'h7e;
  localparam logic [7:0] transmit_queue_command_off = 8'h80;
  localparam logic [7:0] receive_queue_command_off = 8'h82;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int rx_byte_count_field_width = 12; // Byte count, bits 11:0
  localparam int manual_enqueue_enable_bit = 0;
  localparam int tx_memory_available_monitor_bit = 1;
  localparam int auto_enqueue_enable_bit = 2;
  localparam int rx_frame_threshold_status_bit = 10;
  localparam int rx_byte_threshold_status_bit = 11;
  localparam int rx_duration_threshold_status_bit = 12;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] tx_command_reset = 3'h0;
  localparam logic [2:0] rx_status_reset = 3'h0;
  // ----------------------------------------
  // Host APB register byte offsets
  // ----------------------------------------
  localparam logic [7:0] host_command_off = 8'h00; // [7:0] addr [8] write [9] wide [31] go
  localparam logic [7:0] host_wdata_off = 8'h04; // [15:0] write data
  localparam logic [7:0] host_status_off = 8'h08; // [0] busy [1] refused
  localparam logic [7:0] host_rdata_off = 8'h0c; // [15:0] last read data
  localparam int host_cmd_write_bit = 8;
  localparam int host_cmd_wide_bit = 9;
  localparam int host_cmd_go_bit = 31;
  // Host sequencer states, Gray along idle, first, second
  typedef enum logic [1:0] {
    host_idle = 2'b00,
    host_first = 2'b01,
    host_second = 2'b11
  } host_state_type;
endpackage
`default_nettype wire

// ===== queue_reg_link_if.sv
// Register access link between the host end and the device end.
// Assumes both ends run on pclk; the device answers one cycle after a request.
`default_nettype none
interface queue_reg_link_if;
  logic req; // One-cycle request pulse
  logic write; // 1 write, 0 read
  logic wide; // 1 word access, 0 byte access
  logic [7:0] addr; // Byte address; word accesses use even addresses
  logic [15:0] wdata; // Byte accesses use bits 7:0
  logic ack; // One-cycle answer pulse
  logic [15:0] rdata; // Valid with ack
  modport device (input req, write, wide, addr, wdata, output ack, rdata);
  modport host (output req, write, wide, addr, wdata, input ack, rdata);
endinterface
`default_nettype wire

// ===== frame_queue_command_regs.sv
// Device end: receive byte count, transmit queue command and receive
// threshold status registers, reached over the register link.
// Assumes datapath inputs are on pclk and the host keeps one request open.
//
// Function
// - Byte count in bits 11:0, read-only
// - One byte count supplied per received frame
// - Byte mode: host reads low byte first
// - Auto enqueue bit queues every prepared frame
// - Software keeps manual bit zero with auto
// - Monitor raises interrupt bit 6 on space
// - Monitor self-clears after frame; wait for zero
// - Manual bit queues exactly one frame
// - Manual bit self-clears; wait before next frame
// - Bit 12: duration threshold caused interrupt
// - Bit 11: byte count threshold caused interrupt
// - Bit 10: frame count threshold caused interrupt
// - Status bits refresh only on acknowledge write
// - Transmit command bits reset to zero
//
// The APB register port is this design's own decision.
`default_nettype none
module frame_queue_command_regs
  import frame_queue_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  queue_reg_link_if.device link,
  // Byte count of the frame at the head of the receive queue
  input wire logic [11:0] rx_frame_bytes,
  // Pulse: the frame under transmission has finished
  input wire logic tx_frame_done,
  // Free transmit queue space and the amount requested
  input wire logic [15:0] tx_space_free,
  input wire logic [15:0] tx_next_frame_size_request,
  // Live threshold conditions of the receive queue
  input wire logic rx_duration_over,
  input wire logic rx_bytes_over,
  input wire logic rx_frames_over,
  // Pulse: software wrote 1 to the receive interrupt bit
  input wire logic rx_irq_ack_write,
  output logic rx_header_pop, // Pulse: next frame byte count wanted
  output logic tx_enqueue, // Pulse: queue one prepared frame
  output logic tx_auto_enqueue, // Level: queue every prepared frame
  output logic tx_memory_irq, // Pulse: set interrupt status bit 6
  output logic [2:0] rx_threshold_status // {duration, bytes, frames}
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] tx_command; // {auto, monitor, manual}
    logic monitor_fired; // Interrupt already given for this arming
    logic [2:0] rx_status; // Snapshot of threshold causes
    logic [7:0] count_high; // High byte kept for byte-wide reads
    logic ack;
    logic [15:0] rdata;
    logic pop;
    logic enqueue;
    logic mem_irq;
  } state_type;

  state_type state; // Registered state
  state_type next_state; // Next value

  logic [15:0] word_read; // Selected register, word view
  logic [7:0] lane_wdata; // Write data for the addressed lane
  logic hit_tx; // Access to the transmit command word
  logic lane_low; // Access touches bits 7:0
  logic tx_write; // Write landing in bits 7:0 of the command
  logic space_ok; // Requested space is reached

  // ----------------------------------------
  // Read view of the registers
  // ----------------------------------------
  // Reserved bits are wired to zero in every word
  always_comb begin
    word_read = 16'h0000;
    case ({link.addr[7:1], 1'b0})
      rx_frame_header_byte_count_off: begin
        word_read[rx_byte_count_field_width-1:0] = rx_frame_bytes;
      end
      transmit_queue_command_off: begin
        word_read[2:0] = state.tx_command;
      end
      receive_queue_command_off: begin
        word_read[12:10] = state.rx_status;
      end
      default: begin
        word_read = 16'h0000; // Unmapped reads give zero
      end
    endcase
  end

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  always_comb begin
    hit_tx = ({link.addr[7:1], 1'b0} == transmit_queue_command_off);
    lane_low = link.wide || !link.addr[0];
    lane_wdata = link.wdata[7:0];
    tx_write = link.req && link.write && hit_tx && lane_low;
    space_ok = (tx_space_free >= tx_next_frame_size_request);
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_state.ack = 1'b0;
    next_state.pop = 1'b0;
    next_state.enqueue = 1'b0;
    next_state.mem_irq = 1'b0;

    // Self-clear when the frame finishes; a set below wins
    if (tx_frame_done) begin
      next_state.tx_command[manual_enqueue_enable_bit] = 1'b0;
      next_state.tx_command[tx_memory_available_monitor_bit] = 1'b0;
    end

    // Command writes; only bits 2:0 exist, upper lane writes are dropped
    if (tx_write) begin
      next_state.tx_command[auto_enqueue_enable_bit] =
        lane_wdata[auto_enqueue_enable_bit];
      if (lane_wdata[manual_enqueue_enable_bit]) begin
        // One frame per command, even if already pending
        next_state.tx_command[manual_enqueue_enable_bit] = 1'b1;
        next_state.enqueue = 1'b1;
      end
      if (lane_wdata[tx_memory_available_monitor_bit]) begin
        next_state.tx_command[tx_memory_available_monitor_bit] = 1'b1;
        next_state.monitor_fired = 1'b0;
      end
    end

    // Space monitor: one interrupt per arming; firing wins over a re-arm
    if (state.tx_command[tx_memory_available_monitor_bit] && !state.monitor_fired
        && space_ok) begin
      next_state.mem_irq = 1'b1;
      next_state.monitor_fired = 1'b1;
    end

    // Status snapshot moves only on the acknowledge write
    if (rx_irq_ack_write) begin
      next_state.rx_status = {rx_duration_over, rx_bytes_over, rx_frames_over};
    end

    // Answers to every request, one cycle after it; read data for reads
    if (link.req) begin
      next_state.ack = 1'b1;
      next_state.rdata = 16'h0000;
      if (!link.write) begin
        if (link.wide) begin
          next_state.rdata = word_read;
        end else if (!link.addr[0]) begin
          next_state.rdata[7:0] = word_read[7:0];
        end else begin
          next_state.rdata[7:0] = word_read[15:8];
        end
        // Byte mode: low read latches the high half for its pair
        if (!link.wide && !link.addr[0]) begin
          next_state.count_high = word_read[15:8];
        end
        if (!link.wide && link.addr[0] &&
            ({link.addr[7:1], 1'b0} == rx_frame_header_byte_count_off)) begin
          next_state.rdata[7:0] = state.count_high;
        end
        // Finished reading a count: ask for the next frame's count
        if (({link.addr[7:1], 1'b0} == rx_frame_header_byte_count_off) &&
            (link.wide || link.addr[0])) begin
          next_state.pop = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state.tx_command <= tx_command_reset;
      state.monitor_fired <= 1'b0;
      state.rx_status <= rx_status_reset;
      state.count_high <= 8'h00;
      state.ack <= 1'b0;
      state.rdata <= 16'h0000;
      state.pop <= 1'b0;
      state.enqueue <= 1'b0;
      state.mem_irq <= 1'b0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------
  assign link.ack = state.ack;
  assign link.rdata = state.rdata;
  assign rx_header_pop = state.pop;
  assign tx_enqueue = state.enqueue;
  assign tx_auto_enqueue = state.tx_command[auto_enqueue_enable_bit];
  assign tx_memory_irq = state.mem_irq;
  assign rx_threshold_status = state.rx_status;

endmodule
`default_nettype wire

// ===== frame_queue_host.sv
// Host end: takes commands from software over APB and runs them on the
// register link; narrow reads are done as low byte then high byte.
// Assumes the device answers every request with one ack pulse.
`default_nettype none
module frame_queue_host
  import frame_queue_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  queue_reg_link_if.host link
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    host_state_type fsm;
    logic [7:0] addr;
    logic write;
    logic wide;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic refused; // Last command was refused
    logic [1:0] tx_seen; // Last read of {monitor, manual}
    logic req;
    logic pready;
    logic [31:0] prdata;
  } state_type;

  state_type state; // Registered state
  state_type next_state; // Next value
  logic access; // APB access completes this edge
  logic [31:0] read_mux; // APB read view
  logic [15:0] cmd_data; // Write data after masking
  logic tx_cmd; // Command targets the transmit command low byte

  // ----------------------------------------
  // APB read view
  // ----------------------------------------
  always_comb begin
    access = psel && penable && state.pready;
    case (paddr)
      host_command_off: read_mux = {22'h000000, state.wide, state.write, state.addr};
      host_wdata_off: read_mux = {16'h0000, state.wdata};
      host_status_off: read_mux = {30'h00000000, state.refused, state.fsm != host_idle};
      host_rdata_off: read_mux = {16'h0000, state.rdata};
      default: read_mux = 32'h00000000; // Unmapped reads give zero
    endcase
    tx_cmd = (pwdata[7:0] == transmit_queue_command_off);
    cmd_data = state.wdata;
    // Auto enqueue set: manual bit forced to zero
    if (cmd_data[auto_enqueue_enable_bit]) begin
      cmd_data[manual_enqueue_enable_bit] = 1'b0;
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_state.req = 1'b0;
    // Zero-wait slave: ready in the first access cycle
    next_state.pready = psel && !penable && !state.pready;
    if (psel && !penable) begin
      next_state.prdata = read_mux;
    end
    case (state.fsm)
      host_idle: begin
        if (access && pwrite && paddr == host_wdata_off) begin
          next_state.wdata = pwdata[15:0];
        end
        if (access && pwrite && paddr == host_command_off && pwdata[host_cmd_go_bit]) begin
          next_state.addr = pwdata[7:0];
          next_state.write = pwdata[host_cmd_write_bit];
          next_state.wide = pwdata[host_cmd_wide_bit];
          next_state.refused = 1'b0;
          // Bits still pending from the last read: wait for zero
          if (pwdata[host_cmd_write_bit] && tx_cmd &&
              |(state.tx_seen & state.wdata[1:0])) begin
            next_state.refused = 1'b1;
          end else begin
            next_state.fsm = host_first;
            next_state.req = 1'b1;
            // Narrow reads start at the low byte
            if (!pwdata[host_cmd_write_bit] && !pwdata[host_cmd_wide_bit]) begin
              next_state.addr = {pwdata[7:1], 1'b0};
            end
            if (pwdata[host_cmd_write_bit] && tx_cmd) begin
              next_state.wdata = cmd_data;
            end
          end
        end
      end
      host_first: begin
        if (link.ack) begin
          next_state.rdata = link.rdata;
          if (!state.write && state.addr == transmit_queue_command_off) begin
            next_state.tx_seen = link.rdata[1:0];
          end
          if (!state.write && !state.wide) begin
            // Then the high byte of the pair
            next_state.fsm = host_second;
            next_state.addr = {state.addr[7:1], 1'b1};
            next_state.req = 1'b1;
          end else begin
            next_state.fsm = host_idle;
          end
        end
      end
      host_second: begin
        if (link.ack) begin
          next_state.rdata = {link.rdata[7:0], state.rdata[7:0]};
          next_state.fsm = host_idle;
        end
      end
      default: begin
        next_state.fsm = host_idle;
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Outputs, all from flip-flops except pslverr, tied to zero
  // ----------------------------------------
  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = 1'b0;
  assign link.req = state.req;
  assign link.write = state.write;
  assign link.wide = state.wide;
  assign link.addr = state.addr;
  assign link.wdata = state.wdata;

endmodule
`default_nettype wire

// ===== frame_queue_properties.sv
// Concurrent checks on the register link and the device-side outputs.
// Assumes one clock pclk and the asynchronous active-low reset presetn.
`default_nettype none
module frame_queue_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic req,
  input wire logic write,
  input wire logic wide,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic [11:0] rx_frame_bytes,
  input wire logic rx_duration_over,
  input wire logic rx_bytes_over,
  input wire logic rx_frames_over,
  input wire logic rx_irq_ack_write,
  input wire logic rx_header_pop,
  input wire logic tx_enqueue,
  input wire logic tx_auto_enqueue,
  input wire logic tx_memory_irq,
  input wire logic [2:0] rx_threshold_status
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Clocking and reset for every property
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------
  // Link handshake and register behaviour
  // ----------------------------------------
  AST_ACK_AFTER_REQ: assert property (req |=> ack)
    else $error("ack missing one cycle after req");
  AST_ACK_HAS_CAUSE: assert property (ack |-> $past(req))
    else $error("ack without a request");
  AST_COUNT_WORD: assert property (
    req && !write && wide && addr == 8'h7e |=>
      ack && rx_header_pop && rdata == {4'h0, $past(rx_frame_bytes)})
    else $error("byte count word read wrong");
  AST_ENQ_CAUSE: assert property (
    tx_enqueue |-> $past(req && write && addr == 8'h80 && wdata[0]))
    else $error("enqueue pulse without command");
  AST_ENQ_WORD: assert property (
    req && write && wide && addr == 8'h80 && wdata[0] |=> tx_enqueue)
    else $error("manual command did not enqueue");
  AST_AUTO_FOLLOWS: assert property (
    req && write && addr == 8'h80 |=> tx_auto_enqueue == $past(wdata[2]))
    else $error("auto enqueue level not written");
  AST_AUTO_HOLD: assert property (
    !$past(req && write && addr == 8'h80) |-> $stable(tx_auto_enqueue))
    else $error("auto enqueue level moved alone");
  AST_STATUS_LOAD: assert property (
    rx_irq_ack_write |=> rx_threshold_status ==
      $past({rx_duration_over, rx_bytes_over, rx_frames_over}))
    else $error("threshold status not loaded");
  AST_STATUS_HOLD: assert property (
    !$past(rx_irq_ack_write) |-> $stable(rx_threshold_status))
    else $error("threshold status moved alone");
  AST_IRQ_SINGLE: assert property (
    tx_memory_irq |=> !tx_memory_irq [*8])
    else $error("memory interrupt repeated");
  AST_RESET_CLEAR: assert property (
    $rose(presetn) |-> !tx_enqueue && !tx_auto_enqueue && !tx_memory_irq)
    else $error("command outputs not clear after reset");
endmodule
`default_nettype wire

// ===== tb.sv
// Bench: APB master drives the host end, which talks to the device end.
// Assumes the host answers APB with no wait states and never errors.
`default_nettype none
module tb
  import frame_queue_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr;
  logic [11:0] rx_frame_bytes = 12'h000;
  logic tx_frame_done = 1'b0, rx_irq_ack_write = 1'b0; // Datapath pulses
  logic [15:0] tx_space_free = 16'h0, tx_next_frame_size_request = 16'h0;
  logic [2:0] over = 3'h0; // {duration, bytes, frames} conditions
  logic rx_header_pop, tx_enqueue, tx_auto_enqueue, tx_memory_irq;
  logic [2:0] rx_threshold_status;
  logic [15:0] rd; // Last link read result
  logic refused_flag = 1'b0; // Refused bit after the last command
  int errors = 0, compares = 0, cycles = 0, pops = 0, enqs = 0, irqs = 0;

  queue_reg_link_if link_i();
  frame_queue_host i_frame_queue_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_i));
  frame_queue_command_regs i_frame_queue_command_regs (.pclk(pclk), .presetn(presetn),
    .link(link_i), .rx_frame_bytes(rx_frame_bytes), .tx_frame_done(tx_frame_done),
    .tx_space_free(tx_space_free), .tx_next_frame_size_request(tx_next_frame_size_request),
    .rx_duration_over(over[2]), .rx_bytes_over(over[1]), .rx_frames_over(over[0]),
    .rx_irq_ack_write(rx_irq_ack_write), .rx_header_pop(rx_header_pop),
    .tx_enqueue(tx_enqueue), .tx_auto_enqueue(tx_auto_enqueue),
    .tx_memory_irq(tx_memory_irq), .rx_threshold_status(rx_threshold_status));
  frame_queue_checker i_frame_queue_checker (.pclk(pclk), .presetn(presetn),
    .req(link_i.req), .write(link_i.write), .wide(link_i.wide), .addr(link_i.addr),
    .wdata(link_i.wdata), .ack(link_i.ack), .rdata(link_i.rdata),
    .rx_frame_bytes(rx_frame_bytes), .rx_duration_over(over[2]),
    .rx_bytes_over(over[1]), .rx_frames_over(over[0]),
    .rx_irq_ack_write(rx_irq_ack_write), .rx_header_pop(rx_header_pop),
    .tx_enqueue(tx_enqueue), .tx_auto_enqueue(tx_auto_enqueue),
    .tx_memory_irq(tx_memory_irq), .rx_threshold_status(rx_threshold_status));

  // ----------------------------------------
  // Clock, pulse counters and hang guard
  // ----------------------------------------
  always #12.5 pclk = ~pclk;
  // Pre-edge values are read here, so each one-cycle pulse counts once
  always @(posedge pclk) begin
    cycles++;
    if (rx_header_pop === 1'b1) pops++;
    if (tx_enqueue === 1'b1) enqs++;
    if (tx_memory_irq === 1'b1) irqs++;
    if (cycles == 5000) begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic end_of_test();
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // One link access through the host, waiting for busy to drop
  task automatic link_op(input logic [7:0] a, input logic wr, input logic wide,
                         input logic [15:0] wd);
    logic [31:0] r;
    int n;
    apb(1'b1, host_wdata_off, {16'h0, wd}, r);
    apb(1'b1, host_command_off, {1'b1, 21'h0, wide, wr, a}, r);
    n = 0;
    do begin
      apb(1'b0, host_status_off, 32'h0, r);
      n++;
    end while (r[0] !== 1'b0 && n < 50);
    refused_flag = r[1];
    // A host still busy after the limit is a failure
    if (r[0] !== 1'b0) begin
      errors++;
      $display("CHECK FAILED t=%0t busy=%h exp=%h", $time, r[0], 1'b0);
    end
    apb(1'b0, host_rdata_off, 32'h0, r);
    rd = r[15:0];
  endtask
  task automatic pulse_done();
    @(posedge pclk) tx_frame_done <= 1'b1;
    @(posedge pclk) tx_frame_done <= 1'b0;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    link_op(8'h80, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0);
    link_op(8'h82, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0);
  endtask
  task automatic t_count();
    rx_frame_bytes <= 12'habc;
    link_op(8'h7e, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0abc);
    rx_frame_bytes <= 12'h5a5;
    // Count moves between the two byte reads; the pair must not tear
    fork
      link_op(8'h7e, 1'b0, 1'b0, 16'h0000);
      begin
        @(posedge pclk iff link_i.ack === 1'b1);
        rx_frame_bytes <= 12'hfff;
      end
    join
    chk(rd, 32'h05a5);
    chk(pops, 2);
  endtask
  // Reserved bits set alongside the manual bit must stay invisible
  task automatic t_manual();
    link_op(8'h80, 1'b1, 1'b1, 16'hfff9);
    chk(enqs, 1);
    link_op(8'h80, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0001);
    // Bit still reads one, so a second command must be held back
    link_op(8'h80, 1'b1, 1'b1, 16'h0001);
    chk(refused_flag, 1);
    chk(enqs, 1);
    pulse_done();
    link_op(8'h80, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0);
  endtask
  // Host strips the manual bit when auto is set, so no extra enqueue
  task automatic t_auto();
    link_op(8'h80, 1'b1, 1'b1, 16'h0005);
    chk(tx_auto_enqueue, 1);
    chk(enqs, 1);
    link_op(8'h80, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0004);
    link_op(8'h80, 1'b1, 1'b1, 16'h0000);
    chk(tx_auto_enqueue, 0);
  endtask
  task automatic t_monitor();
    tx_space_free <= 16'h0010;
    tx_next_frame_size_request <= 16'h0020;
    link_op(8'h80, 1'b1, 1'b1, 16'h0002);
    repeat (10) @(posedge pclk);
    chk(irqs, 0);
    tx_space_free <= 16'h0020;
    repeat (10) @(posedge pclk);
    chk(irqs, 1);
    link_op(8'h80, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0002);
    pulse_done();
    link_op(8'h80, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0);
  endtask
  task automatic t_status();
    over <= 3'b101;
    link_op(8'h82, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0);
    @(posedge pclk) rx_irq_ack_write <= 1'b1;
    @(posedge pclk) rx_irq_ack_write <= 1'b0;
    over <= 3'b010;
    link_op(8'h82, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h1400);
    @(posedge pclk) rx_irq_ack_write <= 1'b1;
    @(posedge pclk) rx_irq_ack_write <= 1'b0;
    link_op(8'h82, 1'b1, 1'b1, 16'hffff);
    link_op(8'h82, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0800);
  endtask
  // Reset in mid-run must clear a command left standing
  task automatic t_midreset();
    link_op(8'h80, 1'b1, 1'b1, 16'h0004);
    chk(tx_auto_enqueue, 1);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(tx_auto_enqueue, 0);
    presetn <= 1'b1;
    link_op(8'h80, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0);
    link_op(8'h82, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0);
  endtask
  task automatic t_unmapped();
    link_op(8'h90, 1'b1, 1'b1, 16'hffff);
    link_op(8'h90, 1'b0, 1'b1, 16'h0000);
    chk(rd, 32'h0);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_count();
    t_manual();
    t_auto();
    t_monitor();
    t_status();
    t_midreset();
    t_unmapped();
    end_of_test();
  end
endmodule
`default_nettype wire
